// >>> fldbc_drive_model.sv
// model of the drive core feeding output frequency and bus voltage
// assumes the bench sets targets; values settle one pclk later
module fldbc_drive_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [15:0] freq_tgt,
   input wire logic [15:0] volt_tgt,
   output logic [15:0] out_freq,
   output logic [15:0] bus_volt
);
   timeunit 1ns;
   timeprecision 100ps;
   // measurements sampled on the block clock, zero while in reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_freq <= 16'h0000;
         bus_volt <= 16'h0000;
      end else begin
         out_freq <= freq_tgt;
         bus_volt <= volt_tgt;
      end
   end
endmodule : fldbc_drive_model

// >>> fldbc_level_det.sv
// one hysteresis frequency level detector
// assumes threshold in 0.01 Hz, lag in 0.1 % of threshold, freq on pclk
module fldbc_level_det #(
   parameter int W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] freq,
   input wire logic [W-1:0] thr,
   input wire logic [W-1:0] lag_pct,
   output logic level
);
   logic [W+9:0] prod;
   logic [W-1:0] lag_hz;
   logic [W-1:0] low_lvl;
   logic level_reg;
   logic level_next;

   // lag in hz = thr * pct / 1000, low level clamps at zero
   always_comb begin
      prod = (W+10)'(thr) * (W+10)'(lag_pct);
      lag_hz = W'(prod / (W+10)'(1000));
      low_lvl = (lag_hz > thr) ? '0 : thr - lag_hz;
   end

   // set above threshold, clear below threshold minus lag
   always_comb begin
      level_next = level_reg;
      if (freq > thr) begin
         level_next = 1'b1; // [R1] [R3]
      end else if (freq < low_lvl) begin
         level_next = 1'b0; // [R1] [R2] [R3] [R4]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_reg <= 1'b0;
      end else begin
         level_reg <= level_next;
      end
   end

   assign level = level_reg;
endmodule : fldbc_level_det

// >>> fldbc_pkg.sv
// package of constants for the frequency level detect and braking control block
// assumes frequency in 0.01 Hz units, voltage in 0.1 V units, percent in 0.1 % units
// Operation
// R1: level one output sets above threshold, clears below threshold minus lag; default 50.00 Hz.
// R2: level one lag is percent of threshold, 0.0 to 100.0, default 5.0.
// R3: second independent level detector, same hysteresis, default 50.00 Hz, bounded by max freq.
// R4: level two lag is percent of its threshold, 0.0 to 100.0, default 5.0.
// R5: reached output high while frequency within window; window default 0.00 Hz, bounded by max.
// R6: braking starts when enabled and bus voltage reaches threshold, 200.0 to 2000.0 V.
// R7: threshold default by voltage class: 380.0, 700.0, 1120.0 V.
// R8: braking stops when voltage falls below threshold or enable clears.
package fldbc_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_LVL1_THR = 8'h00;
   localparam logic [7:0] OFS_LVL1_LAG = 8'h04;
   localparam logic [7:0] OFS_LVL2_THR = 8'h08;
   localparam logic [7:0] OFS_LVL2_LAG = 8'h0c;
   localparam logic [7:0] OFS_REACH_WIN = 8'h10;
   localparam logic [7:0] OFS_BRK_EN = 8'h14;
   localparam logic [7:0] OFS_BRK_THR = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1c;
   localparam logic [7:0] OFS_INT_STAT = 8'h20;
   localparam logic [7:0] OFS_INT_MASK = 8'h24;
   localparam logic [7:0] OFS_MAX_FREQ = 8'h28;
   // reset values and range limits
   localparam logic [15:0] RST_LVL_THR = 16'h1388; // 50.00 Hz
   localparam logic [15:0] RST_LVL_LAG = 16'h0032; // 5.0 %
   localparam logic [15:0] RST_REACH_WIN = 16'h0000; // 0.00 Hz
   localparam logic [15:0] RST_MAX_FREQ = 16'h1388; // 50.00 Hz
   localparam logic [15:0] LAG_MAX = 16'h03e8; // 100.0 %
   localparam logic [15:0] BRK_THR_MIN = 16'h07d0; // 200.0 V
   localparam logic [15:0] BRK_THR_MAX = 16'h4e20; // 2000.0 V
   localparam logic [15:0] BRK_THR_220 = 16'h0ed8; // 380.0 V
   localparam logic [15:0] BRK_THR_380 = 16'h1b58; // 700.0 V
   localparam logic [15:0] BRK_THR_660 = 16'h2bc0; // 1120.0 V
   // status / interrupt bit positions
   localparam int BIT_LVL1 = 0;
   localparam int BIT_LVL2 = 1;
   localparam int BIT_REACH = 2;
   localparam int BIT_BRAKE = 3;
   localparam int NUM_EVT = 4;
   // voltage class codes
   typedef enum logic [1:0] {FLDBC_V220, FLDBC_V380, FLDBC_V660} fldbc_vclass_t;
endpackage : fldbc_pkg

// >>> fldbc_top.sv
// apb register file, two level detectors, frequency reached and braking control
// assumes out_freq and bus_volt come from logic on pclk; vclass is a strap
module fldbc_top #(
   parameter int W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [W-1:0] out_freq,
   input wire logic [W-1:0] bus_volt,
   input wire logic [1:0] vclass,
   output logic level_one_out,
   output logic level_two_out,
   output logic freq_reached_out,
   output logic brake_out,
   output logic irq
);
   logic [W-1:0] lvl1_thr_reg, lvl1_thr_next;
   logic [W-1:0] lvl1_lag_reg, lvl1_lag_next;
   logic [W-1:0] lvl2_thr_reg, lvl2_thr_next;
   logic [W-1:0] lvl2_lag_reg, lvl2_lag_next;
   logic [W-1:0] reach_win_reg, reach_win_next;
   logic [W-1:0] max_freq_reg, max_freq_next;
   logic brk_en_reg, brk_en_next;
   logic [W-1:0] brk_thr_reg, brk_thr_next;
   logic thr_loaded_reg, thr_loaded_next;
   logic reach_reg, reach_next;
   logic brake_reg, brake_next;
   logic [3:0] int_stat_reg, int_stat_next;
   logic [3:0] int_mask_reg, int_mask_next;
   logic [3:0] evt_prev_reg;
   logic [31:0] prdata_reg, prdata_next;
   logic lvl1, lvl2;
   logic wr, rd, bad;
   logic [W-1:0] wval;
   logic [3:0] evt_now;
   logic [3:0] evt_rise;
   logic [W-1:0] win_lo, win_hi;
   logic [W:0] hi_sum;
   logic [W-1:0] cls_thr;

   // detectors
   fldbc_level_det #(.W(W)) u_det_one (
      .pclk(pclk),
      .presetn(presetn),
      .freq(out_freq),
      .thr(lvl1_thr_reg),
      .lag_pct(lvl1_lag_reg),
      .level(lvl1)
   );

   fldbc_level_det #(.W(W)) u_det_two (
      .pclk(pclk),
      .presetn(presetn),
      .freq(out_freq),
      .thr(lvl2_thr_reg),
      .lag_pct(lvl2_lag_reg),
      .level(lvl2)
   );

   // apb decode, zero wait states
   always_comb begin
      wr = psel && penable && pwrite;
      rd = psel && penable && !pwrite;
      wval = pwdata[W-1:0];
      bad = 1'b0;
      if (paddr > fldbc_pkg::OFS_MAX_FREQ || paddr[1:0] != 2'b00) begin
         bad = 1'b1;
      end
   end

   assign pready = 1'b1;
   assign pslverr = psel && penable && bad;

   // default braking threshold for the strapped voltage class
   always_comb begin
      case (vclass)
         2'd0: cls_thr = fldbc_pkg::BRK_THR_220; // [R7]
         2'd1: cls_thr = fldbc_pkg::BRK_THR_380; // [R7]
         default: cls_thr = fldbc_pkg::BRK_THR_660; // [R7]
      endcase
   end

   // register writes with range clamping
   always_comb begin
      lvl1_thr_next = lvl1_thr_reg;
      lvl1_lag_next = lvl1_lag_reg;
      lvl2_thr_next = lvl2_thr_reg;
      lvl2_lag_next = lvl2_lag_reg;
      reach_win_next = reach_win_reg;
      max_freq_next = max_freq_reg;
      brk_en_next = brk_en_reg;
      brk_thr_next = brk_thr_reg;
      thr_loaded_next = 1'b1;
      int_mask_next = int_mask_reg;
      if (!thr_loaded_reg) begin
         brk_thr_next = cls_thr; // [R7]
      end
      if (wr && !bad) begin
         if (paddr == fldbc_pkg::OFS_LVL1_THR) begin
            lvl1_thr_next = (wval > max_freq_reg) ? max_freq_reg : wval; // [R1]
         end else if (paddr == fldbc_pkg::OFS_LVL1_LAG) begin
            lvl1_lag_next = (wval > fldbc_pkg::LAG_MAX) ? fldbc_pkg::LAG_MAX : wval; // [R2]
         end else if (paddr == fldbc_pkg::OFS_LVL2_THR) begin
            lvl2_thr_next = (wval > max_freq_reg) ? max_freq_reg : wval; // [R3]
         end else if (paddr == fldbc_pkg::OFS_LVL2_LAG) begin
            lvl2_lag_next = (wval > fldbc_pkg::LAG_MAX) ? fldbc_pkg::LAG_MAX : wval; // [R4]
         end else if (paddr == fldbc_pkg::OFS_REACH_WIN) begin
            reach_win_next = (wval > max_freq_reg) ? max_freq_reg : wval; // [R5]
         end else if (paddr == fldbc_pkg::OFS_BRK_EN) begin
            brk_en_next = pwdata[0];
         end else if (paddr == fldbc_pkg::OFS_BRK_THR) begin
            if (wval < fldbc_pkg::BRK_THR_MIN) begin
               brk_thr_next = fldbc_pkg::BRK_THR_MIN; // [R6]
            end else if (wval > fldbc_pkg::BRK_THR_MAX) begin
               brk_thr_next = fldbc_pkg::BRK_THR_MAX; // [R6]
            end else begin
               brk_thr_next = wval;
            end
         end else if (paddr == fldbc_pkg::OFS_INT_MASK) begin
            int_mask_next = pwdata[3:0];
         end else if (paddr == fldbc_pkg::OFS_MAX_FREQ) begin
            max_freq_next = wval;
         end
      end
   end

   // frequency reached: within +/- window of max output freq target
   always_comb begin
      win_lo = (reach_win_reg > max_freq_reg) ? '0 : max_freq_reg - reach_win_reg;
      hi_sum = {1'b0, max_freq_reg} + {1'b0, reach_win_reg};
      win_hi = hi_sum[W] ? '1 : hi_sum[W-1:0];
      reach_next = (out_freq >= win_lo) && (out_freq <= win_hi); // [R5]
   end

   // braking start and stop
   always_comb begin
      brake_next = brake_reg;
      if (!brk_en_reg) begin
         brake_next = 1'b0; // [R6] [R8]
      end else if (bus_volt >= brk_thr_reg) begin
         brake_next = 1'b1; // [R6]
      end else begin
         brake_next = 1'b0; // [R8]
      end
   end

   // sticky interrupt status on rising events, set wins over write-one clear
   always_comb begin
      evt_now = 4'h0;
      evt_now[fldbc_pkg::BIT_LVL1] = lvl1;
      evt_now[fldbc_pkg::BIT_LVL2] = lvl2;
      evt_now[fldbc_pkg::BIT_REACH] = reach_reg;
      evt_now[fldbc_pkg::BIT_BRAKE] = brake_reg;
      evt_rise = evt_now & ~evt_prev_reg;
      int_stat_next = int_stat_reg;
      if (wr && paddr == fldbc_pkg::OFS_INT_STAT) begin
         int_stat_next = int_stat_reg & ~pwdata[3:0];
      end
      int_stat_next = int_stat_next | evt_rise;
   end

   // read mux
   always_comb begin
      prdata_next = 32'h0000_0000;
      if (paddr == fldbc_pkg::OFS_LVL1_THR) begin
         prdata_next[W-1:0] = lvl1_thr_reg;
      end else if (paddr == fldbc_pkg::OFS_LVL1_LAG) begin
         prdata_next[W-1:0] = lvl1_lag_reg;
      end else if (paddr == fldbc_pkg::OFS_LVL2_THR) begin
         prdata_next[W-1:0] = lvl2_thr_reg;
      end else if (paddr == fldbc_pkg::OFS_LVL2_LAG) begin
         prdata_next[W-1:0] = lvl2_lag_reg;
      end else if (paddr == fldbc_pkg::OFS_REACH_WIN) begin
         prdata_next[W-1:0] = reach_win_reg;
      end else if (paddr == fldbc_pkg::OFS_BRK_EN) begin
         prdata_next[0] = brk_en_reg;
      end else if (paddr == fldbc_pkg::OFS_BRK_THR) begin
         prdata_next[W-1:0] = brk_thr_reg;
      end else if (paddr == fldbc_pkg::OFS_STATUS) begin
         prdata_next[3:0] = evt_now;
      end else if (paddr == fldbc_pkg::OFS_INT_STAT) begin
         prdata_next[3:0] = int_stat_reg;
      end else if (paddr == fldbc_pkg::OFS_INT_MASK) begin
         prdata_next[3:0] = int_mask_reg;
      end else if (paddr == fldbc_pkg::OFS_MAX_FREQ) begin
         prdata_next[W-1:0] = max_freq_reg;
      end
   end

   // state registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl1_thr_reg <= fldbc_pkg::RST_LVL_THR;
         lvl1_lag_reg <= fldbc_pkg::RST_LVL_LAG;
         lvl2_thr_reg <= fldbc_pkg::RST_LVL_THR;
         lvl2_lag_reg <= fldbc_pkg::RST_LVL_LAG;
         reach_win_reg <= fldbc_pkg::RST_REACH_WIN;
         max_freq_reg <= fldbc_pkg::RST_MAX_FREQ;
         brk_en_reg <= 1'b0;
         brk_thr_reg <= fldbc_pkg::BRK_THR_660;
         thr_loaded_reg <= 1'b0;
         reach_reg <= 1'b0;
         brake_reg <= 1'b0;
         int_stat_reg <= 4'h0;
         int_mask_reg <= 4'h0;
         evt_prev_reg <= 4'h0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         lvl1_thr_reg <= lvl1_thr_next;
         lvl1_lag_reg <= lvl1_lag_next;
         lvl2_thr_reg <= lvl2_thr_next;
         lvl2_lag_reg <= lvl2_lag_next;
         reach_win_reg <= reach_win_next;
         max_freq_reg <= max_freq_next;
         brk_en_reg <= brk_en_next;
         brk_thr_reg <= brk_thr_next;
         thr_loaded_reg <= thr_loaded_next;
         reach_reg <= reach_next;
         brake_reg <= brake_next;
         int_stat_reg <= int_stat_next;
         int_mask_reg <= int_mask_next;
         evt_prev_reg <= evt_now;
         prdata_reg <= prdata_next;
      end
   end

   // outputs
   assign prdata = (psel && penable && !pwrite) ? prdata_reg : 32'h0000_0000;
   assign level_one_out = lvl1;
   assign level_two_out = lvl2;
   assign freq_reached_out = reach_reg;
   assign brake_out = brake_reg;
   assign irq = |(int_stat_reg & int_mask_reg);
endmodule : fldbc_top

// >>> fldbc_top_asserts.sv
// port checker for the frequency level detect and braking block
// assumes it is bound to fldbc_top, one clock domain
module fldbc_top_asserts #(
   parameter int W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [W-1:0] out_freq,
   input wire logic [W-1:0] bus_volt,
   input wire logic [1:0] vclass,
   input wire logic level_one_out,
   input wire logic level_two_out,
   input wire logic freq_reached_out,
   input wire logic brake_out,
   input wire logic irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // bus handshake and decode
   zero_wait_a: assert property (psel && penable |-> pready) else $error("pready low in access");
   bad_addr_a: assert property (psel && penable && paddr > 8'h28 |-> pslverr) else $error("no error on bad address");
   read_idle_a: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0) else $error("prdata not zero");
   // output causes
   lvl_one_cause_a: assert property ($rose(level_one_out) |-> $past(out_freq) != 0)
      else $error("level one rose at zero frequency");
   lvl_two_cause_a: assert property ($rose(level_two_out) |-> $past(out_freq) != 0)
      else $error("level two rose at zero frequency");
   brake_floor_a: assert property (brake_out |-> $past(bus_volt) >= 16'h07d0) else $error("brake below floor");
   brake_stop_a: assert property (bus_volt < 16'h07d0 |=> !brake_out) else $error("brake kept on low voltage");
   irq_cause_a: assert property ($rose(irq) |-> $past(level_one_out | level_two_out | freq_reached_out | brake_out)
      || $past(psel && penable && pwrite)) else $error("irq rose with no event");
   // main scenarios
   cover property (brake_out);
   cover property ($fell(level_one_out));
   cover property (irq);
endmodule : fldbc_top_asserts

bind fldbc_top fldbc_top_asserts #(.W(W)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .out_freq(out_freq), .bus_volt(bus_volt), .vclass(vclass), .level_one_out(level_one_out),
   .level_two_out(level_two_out), .freq_reached_out(freq_reached_out), .brake_out(brake_out), .irq(irq));

// >>> test_fldbc.sv
// self-checking bench for the frequency level detect and braking block
// assumes fldbc_top, its package and the drive model are compiled first
module test_fldbc;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, serr, l1, l2, rch, brk, irq;
   logic [15:0] freq_tgt = 16'h0000, volt_tgt = 16'h0000, out_freq, bus_volt;
   logic [1:0] vcls = 2'h1;
   int error_cnt = 0, compares = 0, cyc = 0, ben = 0, st = 0, pv = 0, cur, f = 0, v = 0, e1 = 0, e2 = 0;
   int rst_val[11] = '{16'h1388, 16'h32, 16'h1388, 16'h32, 0, 0, 16'h1b58, 0, 0, 0, 16'h1388};
   `define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin error_cnt++; \
      $display("ERROR %s expected %0h seen %0h", n, e, s); end end
   always #12.5 pclk = ~pclk;
   fldbc_top #(.W(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .out_freq(out_freq),
      .bus_volt(bus_volt), .vclass(vcls), .level_one_out(l1), .level_two_out(l2), .freq_reached_out(rch),
      .brake_out(brk), .irq(irq));
   fldbc_drive_model drv (.pclk(pclk), .presetn(presetn), .freq_tgt(freq_tgt), .volt_tgt(volt_tgt),
      .out_freq(out_freq), .bus_volt(bus_volt));
   // one apb transfer, entered just after a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // write then read back one register
   task automatic wr_rd(input logic [7:0] a, input int d, input int e);
      apb(1'b1, a, 32'(d));
      apb(1'b0, a, 32'h0);
      `CHK("register", e, rd)
   endtask : wr_rd
   task automatic test_done();
      if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done
   // hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 8000) begin
         error_cnt++;
         test_done();
      end
   end
   initial begin
      void'($urandom(25));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      // defaults, brake threshold of the 380 V class
      for (int i = 0; i < 11; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         `CHK("default", rst_val[i], rd)
      end
      apb(1'b0, 8'h2c, 32'h0);
      `CHK("unmapped error", 1, serr)
      `CHK("unmapped data", 0, rd)
      // range limits, then working setup
      wr_rd(8'h04, 2000, 1000);
      wr_rd(8'h0c, 1001, 1000);
      wr_rd(8'h00, 16'hffff, 16'h1388);
      wr_rd(8'h18, 100, 2000);
      wr_rd(8'h18, 30000, 20000);
      wr_rd(8'h28, 4000, 4000);
      wr_rd(8'h10, 16'hffff, 4000);
      wr_rd(8'h08, 16'hffff, 4000);
      wr_rd(8'h00, 3000, 3000);
      wr_rd(8'h04, 100, 100);
      wr_rd(8'h08, 2000, 2000);
      wr_rd(8'h0c, 0, 0);
      wr_rd(8'h10, 200, 200);
      wr_rd(8'h18, 5000, 5000);
      // random steps, each changing either brake enable or both freq and volt targets, against the model
      for (int k = 0; k < 64; k++) begin
         if (k % 8 == 0) begin
            ben = $urandom_range(1, 0);
            apb(1'b1, 8'h14, 32'(ben));
         end else begin
            f = $urandom_range(4500, 1500);
            v = $urandom_range(6000, 1000);
            freq_tgt <= 16'(f);
            volt_tgt <= 16'(v);
         end
         repeat (5) @(posedge pclk);
         e1 = f > 3000 ? 1 : (f < 2700 ? 0 : e1);
         e2 = f > 2000 ? 1 : (f < 2000 ? 0 : e2);
         cur = e1 | e2 << 1 | int'(f >= 3800 && f <= 4200) << 2 | int'(ben == 1 && v >= 5000) << 3;
         st |= cur & ~pv;
         pv = cur;
         `CHK("level one", e1, l1)
         `CHK("level two", e2, l2)
         `CHK("reached", cur >> 2 & 1, rch)
         `CHK("brake", cur >> 3 & 1, brk)
         apb(1'b0, 8'h1c, 32'h0);
         `CHK("live status", cur, rd)
      end
      // interrupt pending, masked, unmasked, cleared; a mask bit of one lets its event through
      apb(1'b0, 8'h20, 32'h0);
      `CHK("event status", st, rd)
      `CHK("irq masked", 0, irq)
      apb(1'b1, 8'h24, 32'hf);
      `CHK("irq pending", st != 0, irq)
      apb(1'b1, 8'h24, 32'h0);
      `CHK("irq remasked", 0, irq)
      apb(1'b1, 8'h24, 32'hf);
      apb(1'b1, 8'h20, 32'hf);
      apb(1'b0, 8'h20, 32'h0);
      `CHK("event cleared", 0, rd)
      `CHK("irq cleared", 0, irq)
      // mid-run resets, one per voltage class, brake threshold default
      for (int c = 0; c < 3; c++) begin
         vcls <= 2'(c);
         presetn <= 1'b0;
         repeat (2) @(posedge pclk);
         presetn <= 1'b1;
         repeat (2) @(posedge pclk);
         apb(1'b0, 8'h18, 32'h0);
         `CHK("class threshold", c == 0 ? fldbc_pkg::BRK_THR_220 : (c == 1 ? fldbc_pkg::BRK_THR_380 : fldbc_pkg::BRK_THR_660), rd)
         `CHK("brake after reset", 0, brk)
      end
      test_done();
   end
endmodule : test_fldbc
